// ===== bench/shc_engine_model.sv
// Bus-target side model: ends a launched command after a latency
`default_nettype none
module shc_engine_model (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            cmd_start,
  input  wire logic [2:0]      mode,
  input  wire logic [7:0]      lat,
  output var shc_pkg::shc_evt_t engine_evt,
  output logic                 engine_byte_valid,
  output logic [7:0]           engine_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Responder
  // ****************
  int cnt;
  // Byte lines toggle when idle, so a stale byte never passes for a fresh one
  always @(posedge aclk) begin
    engine_evt <= '0;
    engine_byte_valid <= 1'b0;
    engine_byte <= aresetn ? ~engine_byte : 8'h5A;
    if (!aresetn) cnt <= 0;
    else if (cmd_start) cnt <= int'(lat);
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 3 || cnt == 2) begin
        engine_byte_valid <= 1'b1;
        engine_byte <= 8'hC0 + 8'(cnt);
      end
      if (cnt == 1) engine_evt <= shc_pkg::shc_evt_t'(5'h01 << mode);
    end
  end
endmodule
`default_nettype wire

// ===== bench/shc_host_ctrl_props.sv
// Port-level properties of the host status/control block
`default_nettype none
module shc_host_ctrl_props (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [7:0]        s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [7:0]        s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              cmd_start,
  input wire shc_pkg::shc_evt_t engine_evt,
  input wire logic              engine_byte_valid,
  input wire logic [4:0]        buf_ptr,
  input wire logic              command_done_flag,
  input wire logic              system_mgmt_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Helpers
  // ****************
  logic [7:0] rd_addr_q;
  logic [7:0] wr_addr_q;
  logic [8:0] wr_data_q;
  logic       hc_rd;
  assign hc_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_q <= 8'h00;
      wr_addr_q <= 8'h00;
      wr_data_q <= 9'h000;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wr_addr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wr_data_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_start; cmd_start |-> $rose(s_axi_bvalid) ##1 !cmd_start; endproperty
  a_start: assert property (p_start) else $error("start pulse not one landed write");
  property p_start_src;
    cmd_start |-> wr_addr_q == 8'h08 && wr_data_q[8] && wr_data_q[6] && wr_data_q[4:2] != 3'h7;
  endproperty
  a_start_src: assert property (p_start_src) else $error("start without legal command");
  property p_excl; !(command_done_flag && system_mgmt_irq); endproperty
  a_excl: assert property (p_excl) else $error("both interrupt outputs high");
  property p_ptr_clr; hc_rd |=> buf_ptr == 5'h00; endproperty
  a_ptr_clr: assert property (p_ptr_clr) else $error("pointer kept after control read");
  property p_ptr_inc; engine_byte_valid && !hc_rd |=> buf_ptr == $past(buf_ptr) + 5'h01; endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer missed a byte");
  property p_hc_read;
    s_axi_rvalid && rd_addr_q == 8'h08 |-> (s_axi_rdata & 32'hFFFFFF62) == 32'h0
      && s_axi_rresp == shc_pkg::RESP_OKAY;
  endproperty
  a_hc_read: assert property (p_hc_read) else $error("control read shows write-only bits");
  property p_clear;
    $rose(s_axi_bvalid) && wr_addr_q == 8'h00 && (wr_data_q & 9'h11E) == 9'h11E
      && $past(engine_evt) == '0 |-> !command_done_flag && !system_mgmt_irq;
  endproperty
  a_clear: assert property (p_clear) else $error("interrupt kept after clearing all");
  property p_rise;
    $rose(command_done_flag || system_mgmt_irq) |-> $past(engine_evt) != '0 || $rose(s_axi_bvalid);
  endproperty
  a_rise: assert property (p_rise) else $error("interrupt rose with no cause");
  c_start: cover property (cmd_start);
  c_coll: cover property (engine_evt.collision ##1 (command_done_flag || system_mgmt_irq));
  c_smi: cover property (system_mgmt_irq);
endmodule
bind shc_host_ctrl shc_host_ctrl_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .cmd_start, .engine_evt, .engine_byte_valid, .buf_ptr, .command_done_flag, .system_mgmt_irq);
`default_nettype wire

// ===== bench/smbus_host_status_control_test.sv
// Testbench of the host status block against a model
`default_nettype none
module smbus_host_status_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals and model state
  // ****************
  logic              aclk, aresetn, cmd_start, command_done_flag, system_mgmt_irq, engine_byte_valid;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, engine_byte, elat;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [4:0]        buf_ptr;
  logic [2:0]        emode;
  shc_pkg::shc_evt_t engine_evt;
  int                num_errors, comparisons, flg, busy, ctl, ien, ptr;
  logic [7:0]        bufm [32];
  logic [7:0]        ra [8] = '{8'h00, 8'h08, 8'h20, 8'h28, 8'h24, 8'h0C, 8'h1C, 8'h40};
  shc_host_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmd_start, .cmd_kill(), .cmd_last_byte(),
    .command_select_field(), .pec_enable(), .engine_evt, .engine_byte_valid, .engine_byte,
    .buf_ptr, .buf_byte(), .command_done_flag, .system_mgmt_irq);
  shc_engine_model u_engine (.aclk, .aresetn, .cmd_start, .mode(emode), .lat(elat),
    .engine_evt, .engine_byte_valid, .engine_byte);
  // ****************
  // Model and bus tasks
  // ****************
  function automatic logic [1:0] mresp(input logic [7:0] a, input logic w);
    return (a inside {8'h00, 8'h08, 8'h1C, 8'h20, 8'h28} || (w && a == 8'h24)) ?
      shc_pkg::RESP_OKAY : shc_pkg::RESP_SLVERR;
  endfunction
  function automatic int fl_of(input int m);
    return (m == 4) ? 0 : (m == 3) ? 2 : (m == 0) ? 3 : 1;
  endfunction
  function automatic void mwr(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h00: flg &= ~int'(d[4:1]);
      8'h08: if (busy == 0) begin
        ctl = int'(d & 8'h9D);
        if (d[6] && d[4:2] == 3'h7) flg |= 2;
        else if (d[6]) busy = 1;
      end
      8'h1C: begin
        bufm[ptr] = d;
        ptr = (ptr + 1) % 32;
      end
      8'h24: flg &= ~int'(d[3:0]);
      8'h28: ien = int'(d & 8'h8F);
      default: ;
    endcase
  endfunction
  function automatic logic [7:0] mrd(input logic [7:0] a);
    mrd = 8'h00;
    case (a)
      8'h00: mrd = {3'h0, 4'(flg), 1'(busy)};
      8'h08: begin
        ptr = 0;
        mrd = 8'(ctl);
      end
      8'h1C: begin
        mrd = bufm[ptr];
        ptr = (ptr + 1) % 32;
      end
      8'h20: mrd = 8'(flg);
      8'h28: mrd = 8'(ien);
      default: ;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'($urandom) | 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 50) begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, mresp(a, 1'b1)}, {30'h0, r});
    mwr(a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    v = 1'b0;
    n = 0;
    while (!v && n < 50) begin
      @(negedge aclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      n++;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check("rresp", {30'h0, mresp(a, 1'b0)}, {30'h0, r});
    check("rdata", {24'h000000, mrd(a)}, d);
  endtask
  task automatic irq();
    logic q;
    @(negedge aclk);
    q = |(4'(flg) & 4'(ien) & {3'h7, ctl[0]});
    check("command_done_flag", {31'h0, q & ~ien[7]}, {31'h0, command_done_flag});
    check("system_mgmt_irq", {31'h0, q & ien[7]}, {31'h0, system_mgmt_irq});
  endtask
  task automatic run(input int m, input logic [7:0] c, input logic [7:0] lat);
    int n;
    emode <= 3'(m);
    elat <= lat;
    wr(8'h08, c | 8'h40);
    if (lat > 8'd20) rd(8'h00);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (engine_evt == '0 && n < 300);
    if (n >= 300) num_errors++;
    @(posedge aclk);
    busy = 0;
    flg |= 1 << fl_of(m);
    for (int i = 3; i > 1; i--) mwr(8'h1C, 8'hC0 + 8'(i));
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize();
  end
  initial begin
    logic [7:0] c;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    emode = 3'h4;
    elat = 8'h06;
    {flg, busy, ctl, ien, ptr} = '0;
    foreach (bufm[i]) bufm[i] = 8'h00;
    void'($urandom(36032));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) rd(ra[i]);
    wr(8'h0C, 8'hFF);
    for (int m = 0; m < 5; m++) begin
      wr(8'h28, m[0] ? 8'h8F : 8'h0F);
      c = {1'($urandom), 2'b00, 3'($urandom_range(0, 6)), 2'b01};
      run(m, c, (m == 4) ? 8'd40 : 8'd6);
      rd(8'h00);
      irq();
      wr(8'h00, 8'($urandom) & ~(8'h02 << fl_of(m)));
      rd(8'h00);
      if (m[0]) wr(8'h24, 8'h0F);
      else wr(8'h00, 8'hFF);
      rd(8'h20);
      irq();
    end
    run(4, 8'h10, 8'd6);
    rd(8'h20);
    irq();
    wr(8'h08, 8'h11);
    irq();
    wr(8'h00, 8'h02);
    irq();
    wr(8'h08, 8'h5D);
    rd(8'h00);
    irq();
    wr(8'h24, 8'h02);
    irq();
    for (int i = 0; i < 3; i++) wr(8'h1C, 8'($urandom));
    rd(8'h08);
    repeat (6) rd(8'h1C);
    rd(8'h08);
    rd(8'h1C);
    summarize();
  end
endmodule
`default_nettype wire

// ===== rtl/shc_axil_slave.sv
// AXI4-Lite slave turning bus transfers into one-cycle register strobes
`default_nettype none
module shc_axil_slave (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output shc_pkg::shc_req_t req,
  input  wire logic [7:0]   rd_data,
  input  wire logic         rd_hit
);

  typedef struct packed {
    logic       aw_held;
    logic [7:0] awaddr;
    logic       w_held;
    logic [7:0] wdata;
    logic       wen;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } shc_slv_t;

  shc_slv_t st_q;
  shc_slv_t st_d;

  assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
  assign s_axi_wready  = !st_q.w_held && !st_q.bvalid;
  // One index is shared, so a read waits out the cycle in which a write fires
  assign s_axi_arready = !st_q.rvalid && !(st_q.aw_held && st_q.w_held && !st_q.bvalid);
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rresp   = st_q.rresp;
  assign s_axi_rdata   = {24'h000000, st_q.rdata};

  always_comb begin
    st_d = st_q;
    req  = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_held = 1'b1;
      st_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_held = 1'b1;
      st_d.wdata  = s_axi_wdata[7:0];
      st_d.wen    = s_axi_wstrb[0];
    end
    // Write fires once both halves are held; the response follows one edge later
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
      req.wr       = st_q.awaddr[7:6] == 2'h0;
      req.idx      = st_q.awaddr[5:2];
      req.wdata    = st_q.wdata;
      req.wen      = st_q.wen;
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (req.wr && shc_pkg::reg_hit(req.idx)) ?
                     shc_pkg::RESP_OKAY : shc_pkg::RESP_SLVERR;
    end else if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      req.rd      = s_axi_araddr[7:6] == 2'h0;
      req.idx     = s_axi_araddr[5:2];
      st_d.rvalid = 1'b1;
      st_d.rdata  = (req.rd && rd_hit) ? rd_data : 8'h00;
      st_d.rresp  = (req.rd && rd_hit) ? shc_pkg::RESP_OKAY : shc_pkg::RESP_SLVERR;
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/shc_host_ctrl.sv
// Host status and control registers of a two-wire management bus host controller
`default_nettype none
// Contract
// - Collision ending a command sets status bit 3; write one clears it.
// - Illegal command, unclaimed cycle or target time-out sets device-error bit 2.
// - Writing one to device-error clears it and drops its interrupt; zero does nothing.
// - Completion bit 1 is set only by a successfully terminated command.
// - Completion flag sets even with interrupt enable clear; then no interrupt.
// - Writing one to completion flag clears it and drops its interrupt.
// - Read-only busy bit 0 is high while a command runs, cleared at completion.
// - Any read of host control resets the 32-byte buffer pointer.
// - Host control is 8 bits at 02h, reset 00h, with RW and WO fields.
// - Status bits set by hardware only, cleared by writing one; zero ignored.
module shc_host_ctrl (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   cmd_start,
  output logic                   cmd_kill,
  output logic                   cmd_last_byte,
  output logic [2:0]             command_select_field,
  output logic                   pec_enable,
  input  wire shc_pkg::shc_evt_t engine_evt,
  input  wire logic              engine_byte_valid,
  input  wire logic [7:0]        engine_byte,
  output logic [4:0]             buf_ptr,
  output logic [7:0]             buf_byte,
  output logic                   command_done_flag,
  output logic                   system_mgmt_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                                completion_irq_enable;
    logic [2:0]                          cmd_field;
    logic                                pec_en;
    logic                                smi_route;
    logic                                busy;
    logic                                start_p;
    logic                                kill_p;
    logic                                last_p;
    logic [4:0]                          ptr;
    logic [shc_pkg::BUF_DEPTH-1:0][7:0]  buffer;
  } shc_main_t;

  shc_main_t          st_q;
  shc_main_t          st_d;
  shc_pkg::shc_req_t  req;
  logic [7:0]         rd_data;
  logic               rd_hit;
  logic [3:0]         set_ev;
  logic [3:0]         clr;
  logic               en_wr;
  logic [3:0]         flags;
  logic [3:0]         enable;
  logic               irq;
  logic               wr_status;
  logic               wr_control;
  logic               wr_block;
  logic               rd_block;
  logic               start_req;
  logic               illegal_cmd;
  logic               terminate;
  logic [7:0]         status_byte;
  logic [7:0]         control_byte;

  // ****************************************************************
  // Bus slave and interrupt flags
  // ****************************************************************
  shc_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .req           (req),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  shc_irq u_irq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set_ev    (set_ev),
    .clr       (clr),
    .en_wr     (en_wr),
    .en_data   (req.wdata[3:0]),
    .done_gate (st_q.completion_irq_enable),
    .flags     (flags),
    .enable    (enable),
    .irq       (irq)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign wr_status  = req.wr && req.wen && req.idx == shc_pkg::IDX_HOST_STATUS;
  assign wr_control = req.wr && req.wen && req.idx == shc_pkg::IDX_HOST_CONTROL;
  assign wr_block   = req.wr && req.wen && req.idx == shc_pkg::IDX_BLOCK_DATA;
  assign rd_block   = req.rd && req.idx == shc_pkg::IDX_BLOCK_DATA;
  assign en_wr      = req.wr && req.wen && req.idx == shc_pkg::IDX_IRQ_ENABLE;

  // A start while busy is dropped
  assign start_req   = wr_control && req.wdata[shc_pkg::CTL_START] && !st_q.busy;
  assign illegal_cmd = req.wdata[shc_pkg::CTL_CMD_LSB +: 3] > shc_pkg::CMD_LAST_LEGAL;
  assign terminate   = st_q.busy && |engine_evt;

  // ****************************************************************
  // Status events (flag order: done, target error, collision, failed)
  // ****************************************************************
  always_comb begin
    set_ev[0] = st_q.busy && engine_evt.done_ok;
    set_ev[1] = (start_req && illegal_cmd) ||
                (st_q.busy && (engine_evt.unclaimed || engine_evt.timeout));
    set_ev[2] = st_q.busy && engine_evt.collision;
    set_ev[3] = st_q.busy && engine_evt.failed;
  end

  // Write-one clear from host status or the clear register
  always_comb begin
    clr = 4'h0;
    if (wr_status) begin
      clr = req.wdata[shc_pkg::STS_FAILED:shc_pkg::STS_DONE];
    end
    if (req.wr && req.wen && req.idx == shc_pkg::IDX_IRQ_CLEAR) begin
      clr = req.wdata[3:0];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  assign status_byte  = {3'h0, flags, st_q.busy};
  assign control_byte = {st_q.pec_en, 2'h0, st_q.cmd_field, 1'b0,
                         st_q.completion_irq_enable};

  always_comb begin
    rd_hit  = shc_pkg::reg_hit(req.idx) && req.idx != shc_pkg::IDX_IRQ_CLEAR;
    unique case (req.idx)
      shc_pkg::IDX_HOST_STATUS:  rd_data = status_byte;
      shc_pkg::IDX_HOST_CONTROL: rd_data = control_byte;
      shc_pkg::IDX_BLOCK_DATA:   rd_data = st_q.buffer[st_q.ptr];
      shc_pkg::IDX_IRQ_STATUS:   rd_data = {4'h0, flags};
      shc_pkg::IDX_IRQ_ENABLE:   rd_data = {st_q.smi_route, 3'h0, enable};
      default:                   rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Control, busy and block buffer
  // ****************************************************************
  always_comb begin
    st_d         = st_q;
    st_d.start_p = 1'b0;
    st_d.kill_p  = 1'b0;
    st_d.last_p  = 1'b0;
    if (wr_control && !st_q.busy) begin
      st_d.completion_irq_enable = req.wdata[shc_pkg::CTL_IRQ_EN];
      st_d.cmd_field             = req.wdata[shc_pkg::CTL_CMD_LSB +: 3];
      st_d.pec_en                = req.wdata[shc_pkg::CTL_PEC_EN];
    end
    // Kill and last-byte must still reach a running command
    if (wr_control) begin
      st_d.kill_p = req.wdata[shc_pkg::CTL_KILL];
      st_d.last_p = req.wdata[shc_pkg::CTL_LAST_BYTE];
    end
    if (en_wr) begin
      st_d.smi_route = req.wdata[shc_pkg::IEN_SMI_ROUTE];
    end
    if (terminate) begin
      st_d.busy = 1'b0;
    end
    if (start_req && !illegal_cmd) begin
      st_d.busy    = 1'b1;
      st_d.start_p = 1'b1;
    end
    // Engine fills the buffer during block reads; software may drain it while busy
    if (engine_byte_valid) begin
      st_d.buffer[st_q.ptr] = engine_byte;
      st_d.ptr              = st_q.ptr + 5'h01;
    end else if (wr_block) begin
      st_d.buffer[st_q.ptr] = req.wdata;
      st_d.ptr              = st_q.ptr + 5'h01;
    end else if (rd_block) begin
      st_d.ptr = st_q.ptr + 5'h01;
    end
    if (req.rd && req.idx == shc_pkg::IDX_HOST_CONTROL) begin
      st_d.ptr = 5'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '{completion_irq_enable: shc_pkg::HOST_CONTROL_RESET[shc_pkg::CTL_IRQ_EN],
                cmd_field: shc_pkg::HOST_CONTROL_RESET[shc_pkg::CTL_CMD_LSB +: 3],
                pec_en: shc_pkg::HOST_CONTROL_RESET[shc_pkg::CTL_PEC_EN],
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_start            = st_q.start_p;
  assign cmd_kill             = st_q.kill_p;
  assign cmd_last_byte        = st_q.last_p;
  assign command_select_field = st_q.cmd_field;
  assign pec_enable           = st_q.pec_en;
  assign buf_ptr              = st_q.ptr;
  assign buf_byte             = st_q.buffer[st_q.ptr];
  assign command_done_flag                 = irq && !st_q.smi_route;
  assign system_mgmt_irq      = irq && st_q.smi_route;

endmodule
`default_nettype wire

// ===== rtl/shc_irq.sv
// Sticky event flags with write-one clear, enable mask and one level interrupt
`default_nettype none
module shc_irq (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] set_ev,
  input  wire logic [3:0] clr,
  input  wire logic       en_wr,
  input  wire logic [3:0] en_data,
  input  wire logic       done_gate,
  output logic [3:0]      flags,
  output logic [3:0]      enable,
  output logic            irq
);

  typedef struct packed {
    logic [3:0] flags;
    logic [3:0] enable;
  } shc_irq_st_t;

  shc_irq_st_t st_q;
  shc_irq_st_t st_d;

  always_comb begin
    st_d = st_q;
    // A set in the same cycle as its clear wins, so no event is lost
    st_d.flags = (st_q.flags & ~clr) | set_ev;
    if (en_wr) begin
      st_d.enable = en_data;
    end
  end

  assign flags  = st_q.flags;
  assign enable = st_q.enable;
  // Completion also needs the control enable
  assign irq = |(st_q.flags & st_q.enable & {3'h7, done_gate});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '{flags: 4'h0, enable: shc_pkg::IRQ_ENABLE_RESET};
    end else begin
      st_q <= st_d;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/shc_pkg.sv
// Register map, field layout and carriers of the host status block
`default_nettype none
package shc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [3:0] IDX_HOST_STATUS = 4'h0;
  localparam logic [3:0] IDX_HOST_CONTROL = 4'h2;
  localparam logic [3:0] IDX_BLOCK_DATA = 4'h7;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
  localparam logic [3:0] IDX_IRQ_CLEAR = 4'h9;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'hA;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_TARGET_ERR = 2;
  localparam int STS_COLLISION = 3;
  localparam int STS_FAILED = 4;
  localparam int CTL_IRQ_EN = 0;
  localparam int CTL_KILL = 1;
  localparam int CTL_CMD_LSB = 2;
  localparam int CTL_LAST_BYTE = 5;
  localparam int CTL_START = 6;
  localparam int CTL_PEC_EN = 7;
  localparam int IEN_SMI_ROUTE = 7;
  localparam logic [7:0] HOST_CONTROL_RESET = 8'h00;
  localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
  localparam logic [2:0] CMD_LAST_LEGAL = 3'h6;
  localparam int BUF_DEPTH = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic       wen;
  } shc_req_t;

  typedef struct packed {
    logic done_ok;
    logic collision;
    logic unclaimed;
    logic timeout;
    logic failed;
  } shc_evt_t;

  // Registers live in the low byte of each word, only the low index range is mapped
  function automatic logic reg_hit(input logic [3:0] idx);
    return idx inside {IDX_HOST_STATUS, IDX_HOST_CONTROL, IDX_BLOCK_DATA, IDX_IRQ_STATUS,
                       IDX_IRQ_CLEAR, IDX_IRQ_ENABLE};
  endfunction

endpackage
`default_nettype wire
